//--- logic/frube_alu.sv
// Unary arithmetic unit: clear, complement, decrement and increment of a byte.
// Assumes the operand is the addressed file register's current contents.
`timescale 1ns/10ps
`include "frube_params.svh"

module frube_alu (
	frube_alu_if.unit alu
);

	// =============================================================
	// Result selection
	always_comb
	begin
		case (alu.op)
			frube_pkg::op_clear_file_register:
				alu.result = `FRUBE_BYTE_ZERO;
			frube_pkg::op_complement_file_register:
				alu.result = ~alu.operand;
			frube_pkg::op_decrement_file_register,
			frube_pkg::op_decrement_skip_if_zero:
				alu.result = 8'(alu.operand - `FRUBE_BYTE_ONE);
			frube_pkg::op_increment_file_register,
			frube_pkg::op_increment_skip_if_zero:
				alu.result = 8'(alu.operand + `FRUBE_BYTE_ONE);
			default:
				alu.result = alu.operand;
		endcase
		alu.zero = (alu.result == `FRUBE_BYTE_ZERO);
	end

endmodule // frube_alu

//--- logic/frube_alu_if.sv
// Carrier between the sequencer and the unary arithmetic unit.
// Assumes both ends sit in the same clock domain; the unit is combinational.
`timescale 1ns/10ps
`include "frube_params.svh"

interface frube_alu_if;
	frube_pkg::frube_op_t op;
	logic [`FRUBE_DATA_W-1:0] operand;
	logic [`FRUBE_DATA_W-1:0] result;
	logic zero;

	modport requester (output op, output operand, input result, input zero);
	modport unit (input op, input operand, output result, output zero);
endinterface

//--- logic/frube_exec.sv
// Execution block for single-operand file-register instructions and the branch.
// Assumes a decoder presents one instruction at a time and a register file
// outside supplies the addressed register and applies the write strobes.
//
// Operation
// - Clear writes zero to file, sets zero
// - Complement inverts file contents, updates zero flag
// - Destination bit 0 to W, 1 to file
// - Decrement subtracts one, updates zero flag
// - Decrement-skip subtracts one, flags untouched
// - Zero skip result discards prefetch, two cycles
// - Branch loads immediate plus status page bits
// - Branch takes two cycles, flags untouched
// - Increment adds one, updates zero flag
// - Increment-skip adds one, discards on zero
`timescale 1ns/10ps
`include "frube_params.svh"

module frube_exec #(
	parameter int DATA_W = `FRUBE_DATA_W
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic op_valid,
	input wire frube_pkg::frube_op_t op_code,
	input wire logic [`FRUBE_FILE_ADDR_W-1:0] file_addr,
	input wire logic dest_sel,
	input wire logic [`FRUBE_TARGET_W-1:0] branch_target,
	input wire logic [DATA_W-1:0] file_data,
	input wire logic [DATA_W-1:0] status_in,
	output logic op_ready,
	output logic w_wr_en,
	output logic [DATA_W-1:0] w_wr_data,
	output logic file_wr_en,
	output logic [`FRUBE_FILE_ADDR_W-1:0] file_wr_addr,
	output logic [DATA_W-1:0] file_wr_data,
	output logic zero_wr_en,
	output logic zero_flag,
	output logic pc_load,
	output logic [`FRUBE_PC_W-1:0] pc_value,
	output logic prefetch_discard
);

	// =============================================================
	// Decode helpers
	function automatic logic is_skip(input frube_pkg::frube_op_t op);
		is_skip = (op == frube_pkg::op_decrement_skip_if_zero)
			|| (op == frube_pkg::op_increment_skip_if_zero);
	endfunction

	function automatic logic has_dest(input frube_pkg::frube_op_t op);
		has_dest = (op == frube_pkg::op_complement_file_register)
			|| (op == frube_pkg::op_decrement_file_register)
			|| (op == frube_pkg::op_increment_file_register)
			|| is_skip(op);
	endfunction

	// =============================================================
	// Arithmetic unit
	frube_alu_if alu_bus ();

	assign alu_bus.op = op_code;
	assign alu_bus.operand = file_data;

	frube_alu u_alu (
		.alu(alu_bus)
	);

	// =============================================================
	// Sequencer and result registers
	frube_pkg::frube_state_t state;
	frube_pkg::frube_state_t next_state;
	logic accept;
	logic next_w_wr_en;
	logic [DATA_W-1:0] next_w_wr_data;
	logic next_file_wr_en;
	logic [`FRUBE_FILE_ADDR_W-1:0] next_file_wr_addr;
	logic [DATA_W-1:0] next_file_wr_data;
	logic next_zero_wr_en;
	logic next_zero_flag;
	logic next_pc_load;
	logic [`FRUBE_PC_W-1:0] next_pc_value;
	logic next_prefetch_discard;

	// The slot after a taken skip or a branch holds the discarded fetch.
	assign op_ready = (state == frube_pkg::st_execute);
	assign accept = op_valid && op_ready;

	always_comb
	begin
		next_state = frube_pkg::st_execute;
		next_w_wr_en = 1'b0;
		next_w_wr_data = w_wr_data;
		next_file_wr_en = 1'b0;
		next_file_wr_addr = file_wr_addr;
		next_file_wr_data = file_wr_data;
		next_zero_wr_en = 1'b0;
		next_zero_flag = zero_flag;
		next_pc_load = 1'b0;
		next_pc_value = pc_value;
		next_prefetch_discard = 1'b0;
		if (accept)
		begin
			case (op_code)
				frube_pkg::op_clear_file_register:
				begin
					next_file_wr_en = 1'b1;
					next_file_wr_addr = file_addr;
					next_file_wr_data = alu_bus.result;
					next_zero_wr_en = 1'b1;
					next_zero_flag = 1'b1;
				end
				frube_pkg::op_unconditional_branch:
				begin
					next_pc_load = 1'b1;
					next_pc_value = {status_in[`FRUBE_PAGE_MSB:`FRUBE_PAGE_LSB],
						branch_target};
					next_prefetch_discard = 1'b1;
					next_state = frube_pkg::st_discard;
				end
				default:
				begin
					if (has_dest(op_code))
					begin
						if (dest_sel == `FRUBE_DEST_W)
						begin
							next_w_wr_en = 1'b1;
							next_w_wr_data = alu_bus.result;
						end
						else
						begin
							next_file_wr_en = 1'b1;
							next_file_wr_addr = file_addr;
							next_file_wr_data = alu_bus.result;
						end
						if (is_skip(op_code))
						begin
							// Skip forms leave the zero flag alone.
							if (alu_bus.zero)
							begin
								next_prefetch_discard = 1'b1;
								next_state = frube_pkg::st_discard;
							end
						end
						else
						begin
							next_zero_wr_en = 1'b1;
							next_zero_flag = alu_bus.zero;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state <= frube_pkg::st_execute;
			w_wr_en <= 1'b0;
			w_wr_data <= `FRUBE_BYTE_ZERO;
			file_wr_en <= 1'b0;
			file_wr_addr <= `FRUBE_ADDR_RESET;
			file_wr_data <= `FRUBE_BYTE_ZERO;
			zero_wr_en <= 1'b0;
			zero_flag <= 1'b0;
			pc_load <= 1'b0;
			pc_value <= `FRUBE_PC_RESET;
			prefetch_discard <= 1'b0;
		end
		else
		begin
			state <= next_state;
			w_wr_en <= next_w_wr_en;
			w_wr_data <= next_w_wr_data;
			file_wr_en <= next_file_wr_en;
			file_wr_addr <= next_file_wr_addr;
			file_wr_data <= next_file_wr_data;
			zero_wr_en <= next_zero_wr_en;
			zero_flag <= next_zero_flag;
			pc_load <= next_pc_load;
			pc_value <= next_pc_value;
			prefetch_discard <= next_prefetch_discard;
		end
	end

	// =============================================================
	// Checks
	default clocking chk_clk @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_clear_sets_zero: assert property (
		accept && op_code == frube_pkg::op_clear_file_register |=>
		file_wr_en && file_wr_data == `FRUBE_BYTE_ZERO && zero_wr_en && zero_flag
		&& file_wr_addr == $past(file_addr) && !w_wr_en)
		else $error("clear did not zero the file register and set zero");

	a_complement_value: assert property (
		accept && op_code == frube_pkg::op_complement_file_register && dest_sel |=>
		file_wr_data == ~$past(file_data)
		&& zero_flag == ($past(file_data) == `FRUBE_BYTE_ALL))
		else $error("complement result or zero flag wrong");

	a_dest_to_w: assert property (
		accept && has_dest(op_code) && dest_sel == `FRUBE_DEST_W |=>
		w_wr_en && !file_wr_en)
		else $error("destination 0 did not write W only");

	a_decrement_wrap: assert property (
		accept && op_code == frube_pkg::op_decrement_file_register
		&& file_data == `FRUBE_BYTE_ZERO |=>
		zero_wr_en && !zero_flag && (w_wr_en ? w_wr_data : file_wr_data) == `FRUBE_BYTE_ALL)
		else $error("decrement of zero did not wrap");

	a_skip_flags_kept: assert property (
		accept && (is_skip(op_code) || op_code == frube_pkg::op_unconditional_branch) |=>
		!zero_wr_en)
		else $error("skip or branch touched the zero flag");

	a_dec_skip_taken: assert property (
		accept && op_code == frube_pkg::op_decrement_skip_if_zero
		&& file_data == `FRUBE_BYTE_ONE |=>
		prefetch_discard && !op_ready ##1 op_ready && !prefetch_discard)
		else $error("zero decrement-skip did not discard for one cycle");

	a_branch_target: assert property (
		accept && op_code == frube_pkg::op_unconditional_branch |=>
		pc_load && pc_value == {$past(status_in[`FRUBE_PAGE_MSB:`FRUBE_PAGE_LSB]),
		$past(branch_target)})
		else $error("branch loaded a wrong program counter");

	a_branch_two_cycle: assert property (
		accept && op_code == frube_pkg::op_unconditional_branch |=>
		(!op_ready && prefetch_discard) ##1 op_ready)
		else $error("branch did not take two cycles");

	a_increment_wrap: assert property (
		accept && op_code == frube_pkg::op_increment_file_register
		&& file_data == `FRUBE_BYTE_ALL |=> zero_wr_en && zero_flag)
		else $error("increment of all ones did not give zero");

	a_inc_skip_taken: assert property (
		accept && op_code == frube_pkg::op_increment_skip_if_zero
		&& file_data == `FRUBE_BYTE_ALL |=> prefetch_discard && !zero_wr_en)
		else $error("zero increment-skip did not discard");

	a_skip_not_taken: assert property (
		accept && is_skip(op_code) && !alu_bus.zero |=> op_ready && !prefetch_discard)
		else $error("nonzero skip took a second cycle");

	c_dec_skip_taken: cover property (
		accept && op_code == frube_pkg::op_decrement_skip_if_zero && alu_bus.zero);
	c_inc_skip_not_taken: cover property (
		accept && op_code == frube_pkg::op_increment_skip_if_zero && !alu_bus.zero);
	c_branch: cover property (accept && op_code == frube_pkg::op_unconditional_branch);
	c_back_to_back: cover property (accept ##1 accept);

endmodule // frube_exec

//--- logic/frube_params.svh
// Constants for the file-register unary and branch execution block.
// Assumes an 8-bit datapath, 32 file registers and an 11-bit program counter.
`ifndef FRUBE_PARAMS_SVH
`define FRUBE_PARAMS_SVH

// =============================================================
// Data values
`define FRUBE_BYTE_ZERO 8'h00
`define FRUBE_BYTE_ONE 8'h01
`define FRUBE_BYTE_ALL 8'hFF

// =============================================================
// Destination select encoding
`define FRUBE_DEST_W 1'b0
`define FRUBE_DEST_FILE 1'b1

// =============================================================
// Widths and field positions
`define FRUBE_DATA_W 8
`define FRUBE_FILE_ADDR_W 5
`define FRUBE_TARGET_W 9
`define FRUBE_PC_W 11
`define FRUBE_PAGE_MSB 6
`define FRUBE_PAGE_LSB 5

// =============================================================
// Reset values
`define FRUBE_ADDR_RESET 5'h00
`define FRUBE_PC_RESET 11'h000

`endif

//--- logic/frube_pkg.sv
// Types shared by the execution block and its arithmetic unit.
// Assumes the decoder outside hands over one operation code per instruction.
package frube_pkg;

	// =============================================================
	// Operation codes
	typedef enum logic [2:0] {
		op_no_operation,
		op_clear_file_register,
		op_complement_file_register,
		op_decrement_file_register,
		op_decrement_skip_if_zero,
		op_unconditional_branch,
		op_increment_file_register,
		op_increment_skip_if_zero
	} frube_op_t;

	// =============================================================
	// Sequencer states
	typedef enum logic {
		st_execute,
		st_discard
	} frube_state_t;

endpackage

//--- verification/file_reg_unary_and_branch_exec_test.sv
// Self-checking bench for the unary file-register and branch execution block.
// Assumes frube_exec with its default 8-bit data width and a 250 MHz core clock.
`timescale 1ns/10ps
`include "frube_params.svh"

module file_reg_unary_and_branch_exec_test;
	// =============================================================
	// Strobe bits in the order {w, file, zero, pc, discard, ready}
	localparam logic [5:0] S_W = 6'h20;
	localparam logic [5:0] S_F = 6'h10;
	localparam logic [5:0] S_Z = 6'h08;
	localparam logic [5:0] S_P = 6'h04;
	localparam logic [5:0] S_D = 6'h02;
	localparam logic [5:0] S_R = 6'h01;
	logic sys_clk;
	logic rst;
	logic op_valid;
	frube_pkg::frube_op_t op_code;
	logic [4:0] file_addr;
	logic dest_sel;
	logic [8:0] branch_target;
	logic [7:0] file_data;
	logic [7:0] status_in;
	logic op_ready, w_wr_en, file_wr_en, zero_wr_en, zero_flag, pc_load, prefetch_discard;
	logic [7:0] w_wr_data;
	logic [4:0] file_wr_addr;
	logic [7:0] file_wr_data;
	logic [10:0] pc_value;
	logic [5:0] strb;
	int failures;
	int checked;

	assign strb = {w_wr_en, file_wr_en, zero_wr_en, pc_load, prefetch_discard, op_ready};

	frube_exec i_dut (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
		.file_addr(file_addr), .dest_sel(dest_sel), .branch_target(branch_target),
		.file_data(file_data), .status_in(status_in), .op_ready(op_ready),
		.w_wr_en(w_wr_en), .w_wr_data(w_wr_data), .file_wr_en(file_wr_en),
		.file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .zero_wr_en(zero_wr_en),
		.zero_flag(zero_flag), .pc_load(pc_load), .pc_value(pc_value),
		.prefetch_discard(prefetch_discard));

	// =============================================================
	// Reporting and comparison
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
		begin
			$display("SIMULATION PASSED");
		end
		else
		begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check_strb(input logic [5:0] exp);
		checked++;
		if (strb !== exp)
		begin
			failures++;
			$display("ERROR at %0t: strobes %b, expected %b", $time, strb, exp);
		end
	endtask

	task automatic check_val(input logic [10:0] got, input logic [10:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	// =============================================================
	// Drivers, all changing inputs at the falling edge
	task automatic drive(input frube_pkg::frube_op_t op, input logic [4:0] fa, input logic d,
		input logic [7:0] fd, input logic [8:0] tg, input logic [7:0] st);
		op_code = op;
		file_addr = fa;
		dest_sel = d;
		file_data = fd;
		branch_target = tg;
		status_in = st;
	endtask

	task automatic send(input frube_pkg::frube_op_t op, input logic [4:0] fa, input logic d,
		input logic [7:0] fd, input logic [8:0] tg, input logic [7:0] st);
		@(negedge sys_clk);
		drive(op, fa, d, fd, tg, st);
		op_valid = 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		op_valid = 1'b0;
	endtask

	// Sends one byte operation and checks strobes, destination data and zero flag.
	task automatic unary(input frube_pkg::frube_op_t op, input logic [4:0] fa, input logic d,
		input logic [7:0] fd, input logic [5:0] es, input logic [7:0] ev, input logic ez);
		send(op, fa, d, fd, 9'h000, 8'h00);
		check_strb(es);
		if ((es & S_W) != 6'h00)
		begin
			check_val(11'(w_wr_data), 11'(ev));
		end
		else
		begin
			check_val(11'(file_wr_data), 11'(ev));
			check_val(11'(file_wr_addr), 11'(fa));
		end
		if ((es & S_Z) != 6'h00)
		begin
			check_val(11'(zero_flag), 11'(ez));
		end
	endtask

	// =============================================================
	// Scenarios
	task automatic t_reset();
		check_strb(S_R);
		check_val(pc_value, 11'h000);
		send(frube_pkg::op_no_operation, 5'h01, 1'b1, 8'h00, 9'h000, 8'h00);
		check_strb(S_R);
	endtask

	task automatic t_byte_ops();
		unary(frube_pkg::op_clear_file_register, 5'h1F, 1'b0, 8'h5A, S_F|S_Z|S_R, 8'h00, 1'b1);
		unary(frube_pkg::op_complement_file_register, 5'h03, 1'b0, 8'hFF, S_W|S_Z|S_R, 8'h00, 1'b1);
		unary(frube_pkg::op_complement_file_register, 5'h0A, 1'b1, 8'h0F, S_F|S_Z|S_R, 8'hF0, 1'b0);
		unary(frube_pkg::op_decrement_file_register, 5'h11, 1'b1, 8'h00, S_F|S_Z|S_R, 8'hFF, 1'b0);
		unary(frube_pkg::op_decrement_file_register, 5'h00, 1'b0, 8'h01, S_W|S_Z|S_R, 8'h00, 1'b1);
		unary(frube_pkg::op_increment_file_register, 5'h07, 1'b0, 8'hFF, S_W|S_Z|S_R, 8'h00, 1'b1);
		unary(frube_pkg::op_increment_file_register, 5'h1E, 1'b1, 8'h7F, S_F|S_Z|S_R, 8'h80, 1'b0);
	endtask

	// A zero decrement-skip, with a clear offered in the refused slot.
	task automatic t_skip_dec();
		@(negedge sys_clk);
		drive(frube_pkg::op_decrement_skip_if_zero, 5'h03, 1'b1, 8'h01, 9'h000, 8'h00);
		op_valid = 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		drive(frube_pkg::op_clear_file_register, 5'h04, 1'b0, 8'h33, 9'h000, 8'h00);
		check_strb(S_F|S_D);
		check_val(11'(file_wr_data), 11'h000);
		check_val(11'(file_wr_addr), 11'h003);
		@(posedge sys_clk);
		@(negedge sys_clk);
		op_valid = 1'b0;
		check_strb(S_R);
		unary(frube_pkg::op_decrement_skip_if_zero, 5'h09, 1'b0, 8'h05, S_W|S_R, 8'h04, 1'b0);
		unary(frube_pkg::op_decrement_skip_if_zero, 5'h02, 1'b1, 8'h00, S_F|S_R, 8'hFF, 1'b0);
	endtask

	task automatic t_skip_inc();
		unary(frube_pkg::op_increment_skip_if_zero, 5'h05, 1'b0, 8'hFF, S_W|S_D, 8'h00, 1'b0);
		@(negedge sys_clk);
		check_strb(S_R);
		unary(frube_pkg::op_increment_skip_if_zero, 5'h06, 1'b1, 8'h10, S_F|S_R, 8'h11, 1'b0);
	endtask

	task automatic t_branch();
		send(frube_pkg::op_unconditional_branch, 5'h00, 1'b0, 8'h00, 9'h1A5, 8'h5F);
		check_strb(S_P|S_D);
		check_val(pc_value, 11'h5A5);
		@(negedge sys_clk);
		check_strb(S_R);
		send(frube_pkg::op_unconditional_branch, 5'h00, 1'b1, 8'h00, 9'h1FF, 8'h60);
		check_val(pc_value, 11'h7FF);
		send(frube_pkg::op_unconditional_branch, 5'h00, 1'b1, 8'h00, 9'h000, 8'h9F);
		check_val(pc_value, 11'h000);
	endtask

	// Two instructions taken on consecutive edges, with no idle cycle between them.
	task automatic t_back_to_back();
		@(negedge sys_clk);
		drive(frube_pkg::op_increment_file_register, 5'h08, 1'b0, 8'h41, 9'h000, 8'h00);
		op_valid = 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		drive(frube_pkg::op_decrement_file_register, 5'h09, 1'b1, 8'h01, 9'h000, 8'h00);
		check_strb(S_W|S_Z|S_R);
		check_val(11'(w_wr_data), 11'h042);
		check_val(11'(zero_flag), 11'h000);
		@(posedge sys_clk);
		@(negedge sys_clk);
		op_valid = 1'b0;
		check_strb(S_F|S_Z|S_R);
		check_val(11'(file_wr_data), 11'h000);
		check_val(11'(file_wr_addr), 11'h009);
		check_val(11'(zero_flag), 11'h001);
	endtask

	// =============================================================
	// Clock, watchdog and main sequence
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		$display("ERROR at %0t: run did not finish", $time);
		print_verdict();
	end

	initial
	begin
		failures = 0;
		checked = 0;
		rst = 1'b1;
		op_valid = 1'b0;
		drive(frube_pkg::op_no_operation, 5'h00, 1'b0, 8'h00, 9'h000, 8'h00);
		repeat (12) @(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_byte_ops();
		t_skip_dec();
		t_skip_inc();
		t_branch();
		t_back_to_back();
		print_verdict();
	end
endmodule // file_reg_unary_and_branch_exec_test
